// File: rtl/channel_sequence_control.sv
// main-channel sequencing control with its ahb-lite register slave
// Function
// - end trigger completes a sequence, clears busy, drops on release
// - priority grant sets busy, held until end clears it
// - control-register-full on local fetch done, cleared at sequence end
// - 6 us master reset sets clear trigger; 2 us pulse ends it
// - storage-cycle-done on main storage cycle, cleared at sequence end
// - retain storage makes two main storage fetches per sequence
// - transfer decode latch; transfer cycle refetches, ends on fetch done
// - start latch set on address word fetch, cleared by select drop
// - pseudo test on cpu response for cu interrupt, until released
// - no-selection on select-in, cleared by main or cpu request
// - diagnose line puts the channel in simulate mode
// - outstanding request interrupts start fetches, cleared at its end
// - interrupted write data fetch marked, fetched at next main grant
// - multiplex pseudo start outranks start, cleared at main end
// - selector pseudo start ends once command word is present
// - selector write chain control sets data-only at trigger 3
// - data-only fetches one double word, cleared in chain sequence
// - three multiplex chain data cases, each cleared when done
// - boundary crossing fetches next list word, cleared at its end
// - each request latch clears when its response is granted
// - service latch on op-in and addr-in, until op-in, status-in fall
// - chain sync on device end; reselect latch until status response
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
module channel_sequence_control #(
    parameter int LS_ADDR_BITS = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // cpu and interface lines, datapath events
    input wire chan_seq_pkg::pin_type pins,
    input wire chan_seq_pkg::event_type events,
    // sequencing state and storage control
    output chan_seq_pkg::latch_type latches,
    output logic [2:0] request,
    output logic [2:0] response,
    output logic storage_request,
    output logic ls_clear_write,
    output logic [LS_ADDR_BITS-1:0] ls_clear_address,
    output logic reset_pulse
);
    import chan_seq_pkg::*;

    typedef struct packed {
        pin_type pin1;
        pin_type pin2;
        logic lines_were_up;
        latch_type l;
        logic [2:0] control;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_addr;
        logic [31:0] hrdata;
        logic second_fetch;
        logic storage_request;
        reset_phase_type phase;
        logic [COUNT_BITS-1:0] count;
        logic [LS_ADDR_BITS-1:0] ls_addr;
        logic ls_write;
        logic reset_pulse;
    } state_type;

    state_type s;
    state_type n;
    event_type ev;
    logic seq_end;
    logic busy_start;
    logic lines_down;

    assign ev = events;
    assign seq_end = s.l.busy & ev.seq_done;
    assign busy_start = (|response) & ~s.l.busy & ~s.l.end_seq;
    assign lines_down = ~s.pin2.op_in & ~s.pin2.status_in;

    priority_arbiter #(
        .WIDTH(REQUESTERS)
    ) u_priority_arbiter (
        .clk(clk),
        .rst(rst),
        .request_in({ev.main_request, ev.mpx_request, ev.cpu_request}),
        .enable(s.control),
        .hold(s.l.busy | s.l.end_seq),
        .release_in(s.l.end_seq),
        .request(request),
        .response(response)
    );

    always_comb begin
        n = s;
        n.pin1 = pins;
        n.pin2 = s.pin1;
        n.lines_were_up = s.pin2.op_in | s.pin2.status_in;

        // ahb-lite: zero wait, always okay, read data from address phase
        n.ap_valid = hsel & hready & htrans[1];
        n.ap_write = hwrite;
        n.ap_addr = haddr[7:0];
        if (hsel && hready && htrans[1] && !hwrite) begin
            unique case (haddr[7:0])
                ADDR_CONTROL: n.hrdata = {29'h0, s.control};
                ADDR_STATUS: n.hrdata = {4'h0, s.l};
                ADDR_GRANT: n.hrdata = {26'h0, request, response};
                default: n.hrdata = 32'h0;
            endcase
        end
        if (s.ap_valid && s.ap_write && s.ap_addr == ADDR_CONTROL) begin
            n.control = hwdata[2:0];
        end

        // sequence handshake
        if (busy_start) begin
            n.l.busy = 1'b1;
        end
        if (s.l.end_seq) begin
            n.l.busy = 1'b0;
        end
        if (response == '0) begin
            n.l.end_seq = 1'b0;
        end
        if (seq_end) begin
            n.l.end_seq = 1'b1;
        end

        // clears at sequence end come first so that a set still wins
        if (seq_end) begin
            n.l.control_reg_full = 1'b0;
            n.l.storage_cycle_done = 1'b0;
            n.second_fetch = 1'b0;
            n.l.command_word_present = 1'b0;
        end
        if (s.l.busy && ev.ls_fetch_done) begin
            n.l.control_reg_full = 1'b1;
        end

        // main storage fetches
        n.storage_request = busy_start;
        if (s.l.busy && ev.ms_cycle_done) begin
            if (ev.retain_storage && !s.second_fetch) begin
                n.second_fetch = 1'b1;
                n.storage_request = 1'b1;
            end else begin
                n.l.storage_cycle_done = 1'b1;
            end
        end

        // transfer in channel
        if (s.l.transfer_cycle && ev.command_fetch_done) begin
            n.l.transfer_cycle = 1'b0;
        end
        if (s.l.transfer_in_channel_decoded && s.l.busy) begin
            n.l.transfer_in_channel_decoded = 1'b0;
            n.l.transfer_cycle = 1'b1;
        end
        if (ev.command_fetch && ev.transfer_decode) begin
            n.l.transfer_in_channel_decoded = 1'b1;
        end

        // instruction latches
        if (!s.pin2.select_channel) begin
            n.l.start_io = 1'b0;
        end
        if (ev.address_word_fetch) begin
            n.l.start_io = 1'b1;
            n.l.command_word_required = 1'b1;
        end
        if (s.pin2.cpu_released) begin
            n.l.pseudo_test_io = 1'b0;
        end
        if (response[REQ_CPU] && ev.cu_interrupt) begin
            n.l.pseudo_test_io = 1'b1;
        end
        if (ev.main_request || ev.cpu_request) begin
            n.l.no_selection = 1'b0;
        end
        if (s.pin2.select_in && ev.initial_selection) begin
            n.l.no_selection = 1'b1;
        end
        n.l.simulate_mode = s.pin2.diagnose;

        // interrupted fetches during start
        if (seq_end && response[REQ_MPX]) begin
            n.l.outstanding_request = 1'b0;
        end
        if (seq_end && response[REQ_MAIN]) begin
            n.l.data_required = 1'b0;
            n.l.chain_write_data_required = 1'b0;
            n.l.multiplex_pseudo_start = 1'b0;
        end
        if (s.l.busy && ev.mpx_request) begin
            if (s.l.start_io && (ev.command_fetch || ev.write_data_fetch)) begin
                n.l.outstanding_request = 1'b1;
            end
            if (s.l.start_io && ev.write_data_fetch) begin
                n.l.data_required = 1'b1;
            end
            if (ev.chain_sequence && ev.write_data_fetch) begin
                n.l.chain_write_data_required = 1'b1;
            end
        end

        // command word fetch ownership: pseudo start takes the fetch
        if (ev.command_fetch_done) begin
            n.l.command_word_present = 1'b1;
            if (!s.l.multiplex_pseudo_start && !ev.address_word_fetch) begin
                n.l.command_word_required = 1'b0;
            end
            n.l.selector_pseudo_start = 1'b0;
        end
        if (ev.chain_fetch_request) begin
            n.l.multiplex_pseudo_start = 1'b1;
        end
        if (ev.selector_chain_request) begin
            n.l.selector_pseudo_start = 1'b1;
        end

        // chain data address
        if (ev.chain_data_done) begin
            n.l.data_only = 1'b0;
            n.l.chain_data_in_progress = 1'b0;
            n.l.chain_case_one = 1'b0;
            n.l.chain_case_prefetched = 1'b0;
            n.l.chain_case_write_prefetch = 1'b0;
        end
        if (ev.trigger1 && ev.selector_write_chain) begin
            n.l.selector_write_chain_control = 1'b1;
        end
        if (s.l.selector_write_chain_control && ev.trigger3
            && ev.command_fetch_done) begin
            n.l.data_only = 1'b1;
            n.l.selector_write_chain_control = 1'b0;
        end
        if (ev.chain_data_start) begin
            n.l.chain_data_in_progress = 1'b1;
            n.l.chain_case_one = ev.count_one & ~ev.prefetched;
            n.l.chain_case_prefetched = ev.prefetched;
            n.l.chain_case_write_prefetch = ev.write_prefetch;
        end
        if (ev.list_word_done) begin
            n.l.boundary_crossing_fetch = 1'b0;
        end
        if (ev.boundary_cross) begin
            n.l.boundary_crossing_fetch = 1'b1;
        end

        // multiplex device service and chain reselection
        if (lines_down) begin
            n.l.device_service = 1'b0;
        end
        if (s.pin2.op_in && s.pin2.addr_in) begin
            n.l.device_service = 1'b1;
        end
        if (ev.init_status_response) begin
            n.l.chain_command_reselect = 1'b0;
        end
        if (s.l.chain_command_sync && lines_down && s.lines_were_up) begin
            n.l.chain_command_sync = 1'b0;
            n.l.chain_command_reselect = 1'b1;
        end
        if (ev.chain_sequence && s.pin2.device_end) begin
            n.l.chain_command_sync = 1'b1;
        end

        // master reset: hold, clear local storage, then reset pulse
        n.ls_write = 1'b0;
        n.reset_pulse = 1'b0;
        unique case (s.phase)
            RESET_IDLE: begin
                n.count = '0;
                if (s.pin2.master_reset) begin
                    n.phase = RESET_HOLD;
                end
            end
            RESET_HOLD: begin
                n.count = s.count + 1'b1;
                if (!s.pin2.master_reset) begin
                    n.phase = RESET_IDLE;
                end else if (s.count ==
                    COUNT_BITS'(MASTER_RESET_CYCLES - 1)) begin
                    n.phase = RESET_CLEAR;
                    n.l.master_reset_active = 1'b1;
                    n.ls_addr = '0;
                    n.ls_write = 1'b1;
                end
            end
            RESET_CLEAR: begin
                n.count = '0;
                n.ls_addr = s.ls_addr + 1'b1;
                n.ls_write = 1'b1;
                if (s.ls_addr == '1) begin
                    n.ls_write = 1'b0;
                    n.phase = RESET_PULSE;
                    n.reset_pulse = 1'b1;
                end
            end
            RESET_PULSE: begin
                n.count = s.count + 1'b1;
                n.reset_pulse = 1'b1;
                if (s.count == COUNT_BITS'(RESET_PULSE_CYCLES - 1)) begin
                    n.reset_pulse = 1'b0;
                    n.l.master_reset_active = 1'b0;
                    n.phase = RESET_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
            s.control <= CONTROL_RESET;
            s.phase <= RESET_IDLE;
        end else begin
            s <= n;
        end
    end

    // the slave never stalls, so its ready and response stay constant
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s.hrdata;
    assign latches = s.l;
    assign storage_request = s.storage_request;
    assign ls_clear_write = s.ls_write;
    assign ls_clear_address = s.ls_addr;
    assign reset_pulse = s.reset_pulse;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    property p_end_clears_busy;
        s.l.end_seq |=> !s.l.busy;
    endproperty
    a_end_clears_busy: assert property (p_end_clears_busy)
        else $error("busy stayed after end");

    property p_end_drops_on_release;
        s.l.end_seq && response == '0 |=> !s.l.end_seq;
    endproperty
    a_end_drops_on_release: assert property (p_end_drops_on_release)
        else $error("end stayed after release");

    property p_busy_held;
        busy_start |=> s.l.busy ##0 (s.l.busy || $past(s.l.end_seq));
    endproperty
    a_busy_held: assert property (p_busy_held)
        else $error("busy not set on grant");

    property p_busy_until_end;
        s.l.busy && !s.l.end_seq |=> s.l.busy;
    endproperty
    a_busy_until_end: assert property (p_busy_until_end)
        else $error("busy fell without end");

    property p_creg_cleared;
        seq_end && !ev.ls_fetch_done |=> !s.l.control_reg_full;
    endproperty
    a_creg_cleared: assert property (p_creg_cleared)
        else $error("control register full not cleared");

    property p_reset_hold;
        $rose(s.l.master_reset_active) |->
            $past(s.count) == COUNT_BITS'(MASTER_RESET_CYCLES - 1);
    endproperty
    a_reset_hold: assert property (p_reset_hold)
        else $error("master reset trigger set early");

    property p_reset_pulse;
        $fell(s.l.master_reset_active) |->
            $past(s.reset_pulse) && $past(s.count) ==
            COUNT_BITS'(RESET_PULSE_CYCLES - 1);
    endproperty
    a_reset_pulse: assert property (p_reset_pulse)
        else $error("reset pulse length wrong");

    property p_retain_two;
        s.l.busy && ev.ms_cycle_done && ev.retain_storage && !s.second_fetch
            |=> storage_request && !s.l.storage_cycle_done;
    endproperty
    a_retain_two: assert property (p_retain_two)
        else $error("retain storage did not refetch");

    property p_start_clear;
        !s.pin2.select_channel && !ev.address_word_fetch |=> !s.l.start_io;
    endproperty
    a_start_clear: assert property (p_start_clear)
        else $error("start latch held without select");

    property p_simulate;
        ##1 s.l.simulate_mode == $past(s.pin2.diagnose);
    endproperty
    a_simulate: assert property (p_simulate)
        else $error("simulate mode does not follow diagnose");

    property p_one_response;
        $onehot0(response);
    endproperty
    a_one_response: assert property (p_one_response)
        else $error("more than one response");

    property p_no_grant_busy;
        $rose(|response) |-> !s.l.busy && !s.l.end_seq;
    endproperty
    a_no_grant_busy: assert property (p_no_grant_busy)
        else $error("grant while busy");

    property p_service_drop;
        s.l.device_service && lines_down && !s.pin2.addr_in
            |=> !s.l.device_service;
    endproperty
    a_service_drop: assert property (p_service_drop)
        else $error("service latch held after lines fell");

    property p_reselect;
        $rose(s.l.chain_command_reselect) |-> $past(s.l.chain_command_sync);
    endproperty
    a_reselect: assert property (p_reselect)
        else $error("reselect without sync");

    c_sequence: cover property (busy_start ##[1:50] s.l.end_seq);
    c_master_reset: cover property ($fell(s.l.master_reset_active));
    c_reselect: cover property ($rose(s.l.chain_command_reselect));
    c_retain: cover property (s.second_fetch && s.l.storage_cycle_done);
endmodule

// File: rtl/chan_seq_pkg.sv
// timing, bus map, carriers and state codes of the channel sequencing
package chan_seq_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int MASTER_RESET_NS = 6000;
    localparam int RESET_PULSE_NS = 2000;
    localparam int MASTER_RESET_CYCLES =
        (MASTER_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_PULSE_CYCLES = RESET_PULSE_NS / CLK_PERIOD_NS;
    localparam int COUNT_BITS = 16;

    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_GRANT = 8'h08;
    localparam logic [2:0] CONTROL_RESET = 3'h7;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    localparam int REQ_CPU = 0;
    localparam int REQ_MPX = 1;
    localparam int REQ_MAIN = 2;
    localparam int REQUESTERS = 3;

    typedef enum logic [1:0] {
        RESET_IDLE = 2'h0,
        RESET_HOLD = 2'h1,
        RESET_CLEAR = 2'h3,
        RESET_PULSE = 2'h2
    } reset_phase_type;

    // lines from the cpu and the multiplex interface
    typedef struct packed {
        logic select_channel;
        logic diagnose;
        logic op_in;
        logic addr_in;
        logic status_in;
        logic select_in;
        logic device_end;
        logic master_reset;
        logic cpu_released;
    } pin_type;

    // one-cycle events from the channel datapath, same clock
    typedef struct packed {
        logic seq_done;
        logic ls_fetch_done;
        logic ms_cycle_done;
        logic retain_storage;
        logic transfer_decode;
        logic address_word_fetch;
        logic command_fetch;
        logic write_data_fetch;
        logic command_fetch_done;
        logic cu_interrupt;
        logic initial_selection;
        logic chain_sequence;
        logic chain_fetch_request;
        logic selector_chain_request;
        logic trigger1;
        logic trigger3;
        logic selector_write_chain;
        logic chain_data_start;
        logic count_one;
        logic prefetched;
        logic write_prefetch;
        logic chain_data_done;
        logic boundary_cross;
        logic list_word_done;
        logic init_status_response;
        logic mpx_request;
        logic cpu_request;
        logic main_request;
    } event_type;

    typedef struct packed {
        logic busy;
        logic end_seq;
        logic control_reg_full;
        logic master_reset_active;
        logic storage_cycle_done;
        logic transfer_in_channel_decoded;
        logic transfer_cycle;
        logic start_io;
        logic pseudo_test_io;
        logic no_selection;
        logic simulate_mode;
        logic outstanding_request;
        logic data_required;
        logic chain_write_data_required;
        logic multiplex_pseudo_start;
        logic command_word_required;
        logic selector_pseudo_start;
        logic command_word_present;
        logic selector_write_chain_control;
        logic data_only;
        logic chain_data_in_progress;
        logic chain_case_one;
        logic chain_case_prefetched;
        logic chain_case_write_prefetch;
        logic boundary_crossing_fetch;
        logic device_service;
        logic chain_command_sync;
        logic chain_command_reselect;
    } latch_type;
endpackage

// File: rtl/priority_arbiter.sv
// fixed-order priority arbiter for the cpu, multiplex and main requesters
module priority_arbiter #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // request pulses, enables and sequence state
    input wire logic [WIDTH-1:0] request_in,
    input wire logic [WIDTH-1:0] enable,
    input wire logic hold,
    input wire logic release_in,
    // latched requests and active response
    output logic [WIDTH-1:0] request,
    output logic [WIDTH-1:0] response
);
    import chan_seq_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] request;
        logic [WIDTH-1:0] response;
    } arb_state_type;

    arb_state_type s;
    arb_state_type n;

    // lowest index wins: cpu, then multiplex, then main channel
    function automatic logic [WIDTH-1:0] pick_first(
        input logic [WIDTH-1:0] v
    );
        logic [WIDTH-1:0] r;
        r = '0;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = '0;
                r[i] = 1'b1;
            end
        end
        return r;
    endfunction

    always_comb begin
        n = s;
        if (release_in) begin
            n.response = '0;
        end else if (s.response == '0 && !hold) begin
            n.response = pick_first(s.request & enable);
        end
        // a fresh request in the grant cycle is kept
        n.request = (s.request & ~n.response) | request_in;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign request = s.request;
    assign response = s.response;
endmodule

// File: testbench/storage_unit_model.sv
// storage bus unit stand-in: answers each fetch after a set delay
module storage_unit_model #(
    parameter int DELAY = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // fetch start and completion
    input wire logic storage_request,
    output logic cycle_done
);
    timeunit 1ns;
    timeprecision 100ps;
    int count;
    // one fetch at a time; a new request restarts the count
    always @(posedge clk) begin
        if (rst || storage_request) begin
            count <= rst ? 0 : DELAY;
            cycle_done <= 1'b0;
        end else begin
            cycle_done <= (count == 1);
            if (count > 0) begin
                count <= count - 1;
            end
        end
    end
endmodule

// File: testbench/channel_sequence_control_tb.sv
// self-checking bench for the channel sequencing control
module channel_sequence_control_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import chan_seq_pkg::*;
    logic clk, rst, hsel, hwrite, hreadyout, hresp, sreq, ms_done;
    logic rpulse, lsw;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, request, response;
    pin_type pins;
    event_type ev, evs, e;
    latch_type lat;
    int num_errors, comparisons;
    always_comb begin
        evs = ev;
        evs.ms_cycle_done = ms_done;
    end
    channel_sequence_control #(.LS_ADDR_BITS(4)) u_channel_sequence_control (
        .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pins(pins),
        .events(evs), .latches(lat), .request(request), .response(response),
        .storage_request(sreq), .ls_clear_write(lsw), .ls_clear_address(),
        .reset_pulse(rpulse));
    storage_unit_model u_storage_unit_model (.clk(clk), .rst(rst),
        .storage_request(sreq), .cycle_done(ms_done));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task print_verdict;
        $display("checks %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        comparisons++;
        if (g !== x) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, x, g);
        end
    endtask
    // hready is sampled at each edge; nothing moves before it is high
    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= HTRANS_NONSEQ;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans <= 2'h0; hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task pulse(input event_type p);
        @(posedge clk);
        ev <= p;
        @(posedge clk);
        ev <= '0;
    endtask
    task neg(input int n);
        repeat (n) @(negedge clk);
    endtask
    task endseq;
        event_type x;
        x = '0;
        x.seq_done = 1'b1;
        pulse(x);
        neg(1);
        chk("end_seq", 32'h1, 32'(lat.end_seq));
        neg(1);
        chk("busy", 32'h0, 32'(lat.busy));
        chk("st_done", 32'h0, 32'(lat.storage_cycle_done));
        chk("c_full", 32'h0, 32'(lat.control_reg_full));
        neg(2);
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        print_verdict;
    end
    initial begin
        rst = 1'b1; hsel = 1'b0; haddr = '0; hwrite = 1'b0; htrans = 2'h0;
        hsize = 3'h2; hwdata = '0; pins = '0; ev = '0; e = '0;
        num_errors = 0; comparisons = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, 32'h0, 32'h0);
        chk("control", 32'h7, rd);
        bus(1'b0, 32'hc, 32'h0);
        chk("unmapped", 32'h0, rd);
        chk("hresp", 32'h0, 32'(hresp));
        $display("test registers done");
        e.cpu_request = 1'b1;
        pulse(e);
        neg(4);
        chk("response", 32'h1, 32'(response));
        chk("request", 32'h0, 32'(request));
        chk("busy", 32'h1, 32'(lat.busy));
        e = '0;
        e.ls_fetch_done = 1'b1;
        pulse(e);
        neg(8);
        chk("c_full", 32'h1, 32'(lat.control_reg_full));
        chk("st_done", 32'h1, 32'(lat.storage_cycle_done));
        endseq;
        $display("test sequence done");
        bus(1'b1, 32'h0, 32'h6);
        e = '0;
        e.cpu_request = 1'b1;
        e.mpx_request = 1'b1;
        pulse(e);
        neg(3);
        chk("response", 32'h2, 32'(response));
        chk("request", 32'h1, 32'(request));
        endseq;
        bus(1'b1, 32'h0, 32'h7);
        neg(4);
        chk("response", 32'h1, 32'(response));
        endseq;
        $display("test priority done");
        @(posedge clk);
        pins.select_channel <= 1'b1;
        pins.diagnose <= 1'b1;
        e = '0;
        e.address_word_fetch = 1'b1;
        pulse(e);
        neg(2);
        chk("start_io", 32'h1, 32'(lat.start_io));
        chk("simulate", 32'h1, 32'(lat.simulate_mode));
        @(posedge clk);
        pins.select_channel <= 1'b0;
        pins.diagnose <= 1'b0;
        neg(5);
        chk("start_io", 32'h0, 32'(lat.start_io));
        chk("simulate", 32'h0, 32'(lat.simulate_mode));
        $display("test instructions done");
        @(posedge clk);
        pins.op_in <= 1'b1;
        pins.addr_in <= 1'b1;
        pins.device_end <= 1'b1;
        neg(2);
        e = '0;
        e.chain_sequence = 1'b1;
        pulse(e);
        neg(1);
        chk("service", 32'h1, 32'(lat.device_service));
        chk("chain_command_sync", 32'h1, 32'(lat.chain_command_sync));
        @(posedge clk);
        pins.op_in <= 1'b0;
        pins.addr_in <= 1'b0;
        pins.device_end <= 1'b0;
        neg(4);
        chk("service", 32'h0, 32'(lat.device_service));
        chk("reselect", 32'h1, 32'(lat.chain_command_reselect));
        e = '0;
        e.init_status_response = 1'b1;
        pulse(e);
        neg(1);
        chk("reselect", 32'h0, 32'(lat.chain_command_reselect));
        $display("test interface done");
        @(posedge clk);
        pins.master_reset <= 1'b1;
        neg(242);
        chk("mreset", 32'h0, 32'(lat.master_reset_active));
        neg(2);
        chk("mreset", 32'h1, 32'(lat.master_reset_active));
        chk("ls_clear", 32'h1, 32'(lsw));
        @(posedge clk);
        pins.master_reset <= 1'b0;
        neg(16);
        chk("rpulse", 32'h1, 32'(rpulse));
        neg(80);
        chk("mreset", 32'h0, 32'(lat.master_reset_active));
        chk("rpulse", 32'h0, 32'(rpulse));
        $display("test master reset done");
        print_verdict;
    end
endmodule
